/* design/pqci_consts.svh */
// Register offsets, reset values and codes of the queue/config interrupt block
`ifndef PQCI_CONSTS_SVH
`define PQCI_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PQCI_OFS_QSEL   8'h00
`define PQCI_OFS_QVEC   8'h04
`define PQCI_OFS_CVEC   8'h08
`define PQCI_OFS_CAUSE  8'h0c
`define PQCI_OFS_STAT   8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define PQCI_CAUSE_QUEUE 0
`define PQCI_CAUSE_CFG   1
`define PQCI_STAT_INTX   0
`define PQCI_STAT_MSIX   1
`define PQCI_STAT_SEND   2

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define PQCI_NO_VECTOR  16'hffff
`define PQCI_VEC_MAX    16'h07ff
`define PQCI_QSEL_RST   16'h0000
`define PQCI_CAUSE_RST  2'h0

`endif

/* design/pqci_pkg.sv */
// Types shared by the queue/config interrupt block
package pqci_pkg;

    typedef logic [15:0] pqci_vec_t;

    typedef enum logic [0:0] {
        PQCI_IDLE = 1'b0,
        PQCI_SEND = 1'b1
    } pqci_send_t;

endpackage

/* design/pqci_vec_map.sv */
// One event-to-vector mapping register
`include "pqci_consts.svh"

module pqci_vec_map import pqci_pkg::*; #(
    parameter logic [15:0] TABLE_SIZE = `PQCI_VEC_MAX
) (
    input  wire logic      clk,    // Block clock
    input  wire logic      rst_n,  // Synchronous reset, active low
    input  wire logic      ce,     // Clock enable
    input  wire logic      wr,     // Write this mapping
    input  wire pqci_vec_t wdata,  // Requested vector
    output pqci_vec_t      vec     // Vector now mapped
);

    typedef struct packed {
        pqci_vec_t vec;
    } pqci_map_state_t;

    pqci_map_state_t s;
    pqci_map_state_t next_s;

    always_comb begin
        next_s = s;
        if (wr) begin
            // Vectors beyond the table cannot be honoured and read back unmapped
            if (wdata <= TABLE_SIZE && wdata <= `PQCI_VEC_MAX)
                next_s.vec = wdata;
            else
                next_s.vec = `PQCI_NO_VECTOR;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            s.vec <= `PQCI_NO_VECTOR;
        else if (ce)
            s <= next_s;
    end

    assign vec = s.vec;

endmodule

/* design/pqci_pick.sv */
// Lowest-index picker over pending interrupt events
module pqci_pick #(
    parameter int N  = 5,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  req,    // Pending requests
    output logic               found,  // At least one request
    output logic [IW-1:0]      idx     // Lowest pending index
);

    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end

endmodule

/* design/pqci_top.sv */
// Used-buffer and config-change interrupt signalling for a paravirtual PCI function
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "pqci_consts.svh"

// Operation
// - MSI-X off: a queue event sets cause bit 0, then legacy interrupt asserts.
// - MSI-X on: a queue event sends the message at that queue's mapped vector.
// - MSI-X on: a queue mapped to no vector delivers nothing.
// - MSI-X off: a config change sets cause bit 1, then legacy interrupt asserts.
// - MSI-X on: a config change sends the message at the config vector.
// - MSI-X on: config mapped to no vector delivers nothing.
// - One delivery may cover several queues and a config change together.
// - Reading the cause field returns it and clears it to zero.
// - Valid vectors are table entries 0 to 0x7ff; others are unmapped or invalid.
// - Reading a mapping returns the mapped vector or the unmapped code.
// - Reset returns every queue and the config event to unmapped.
// - An unhonourable mapping reads back as the unmapped code.
module pqci_top import pqci_pkg::*; #(
    parameter int          NQ         = 4,
    parameter logic [15:0] TABLE_SIZE = `PQCI_VEC_MAX
) (
    input  wire logic          REF_CLK,    // Block clock, 20 MHz
    input  wire logic          RST_N,      // Synchronous reset, active low
    input  wire logic          CE,         // Clock enable, freezes state when low
    input  wire logic [7:0]    REG_ADDR,   // Register byte address
    input  wire logic [31:0]   REG_WDATA,  // Register write data
    input  wire logic          REG_WR,     // Register write strobe
    input  wire logic          REG_RD,     // Register read strobe
    output logic      [31:0]   REG_RDATA,  // Read data, cycle after the strobe
    input  wire logic          MSIX_EN,    // MSI-X enabled in config space
    input  wire logic [NQ-1:0] QUEUE_EVT,  // Used-buffer notification needed, per queue
    input  wire logic          CFG_EVT,    // Device configuration changed
    input  wire logic          MSIX_ACK,   // Message taken by the PCI core
    output logic               MSIX_REQ,   // Message request
    output logic      [10:0]   MSIX_VEC,   // Table entry of the message
    output logic               INTX_N      // Legacy interrupt, active low
);

    localparam int NE = NQ + 1;
    localparam int IW = $clog2(NE);

    typedef struct packed {
        logic [15:0]   qsel;
        logic [1:0]    cause;
        logic          intx;
        logic [NE-1:0] pend;
        pqci_send_t    fsm;
        pqci_vec_t     vec;
        logic [31:0]   rdata;
    } pqci_state_t;

    pqci_state_t   s;
    pqci_state_t   next_s;
    pqci_vec_t     map_vec [NE];
    logic [NE-1:0] map_wr;
    logic [NE-1:0] mapped;
    logic [NE-1:0] same_vec;
    logic [NE-1:0] evt;
    logic          pick_found;
    logic [IW-1:0] pick_idx;
    pqci_vec_t     sel_vec;

    // ****************************************************************
    // Vector mapping registers, last entry is the config event
    // ****************************************************************
    for (genvar g = 0; g < NE; g++) begin : g_map
        if (g < NQ) begin : g_q
            assign map_wr[g] = REG_WR && REG_ADDR == `PQCI_OFS_QVEC && s.qsel == 16'(g);
        end else begin : g_c
            assign map_wr[g] = REG_WR && REG_ADDR == `PQCI_OFS_CVEC;
        end
        pqci_vec_map #(
            .TABLE_SIZE (TABLE_SIZE)
        ) u_map (
            .clk   (REF_CLK),
            .rst_n (RST_N),
            .ce    (CE),
            .wr    (map_wr[g]),
            .wdata (REG_WDATA[15:0]),
            .vec   (map_vec[g])
        );
        assign mapped[g]   = map_vec[g] != `PQCI_NO_VECTOR;
        assign same_vec[g] = map_vec[g] == s.vec;
    end

    assign evt = {CFG_EVT, QUEUE_EVT};

    pqci_pick #(
        .N  (NE),
        .IW (IW)
    ) u_pick (
        .req   (s.pend & mapped),
        .found (pick_found),
        .idx   (pick_idx)
    );

    // Selected queue's mapping; queues beyond the count read unmapped
    always_comb begin
        sel_vec = `PQCI_NO_VECTOR;
        for (int i = 0; i < NQ; i++) begin
            if (s.qsel == 16'(i))
                sel_vec = map_vec[i];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;

        if (REG_WR && REG_ADDR == `PQCI_OFS_QSEL)
            next_s.qsel = REG_WDATA[15:0];

        // Read clears the cause field; a cause arriving in the same cycle survives
        if (REG_RD && REG_ADDR == `PQCI_OFS_CAUSE)
            next_s.cause = `PQCI_CAUSE_RST;
        if (!MSIX_EN) begin
            if (|QUEUE_EVT)
                next_s.cause[`PQCI_CAUSE_QUEUE] = 1'b1;
            if (CFG_EVT)
                next_s.cause[`PQCI_CAUSE_CFG] = 1'b1;
        end
        // Legacy line follows the cause field one cycle behind
        next_s.intx = |s.cause;

        case (s.fsm)
            PQCI_IDLE: begin
                if (MSIX_EN && pick_found) begin
                    next_s.vec = map_vec[pick_idx];
                    next_s.fsm = PQCI_SEND;
                end
            end
            PQCI_SEND: begin
                if (!MSIX_EN) begin
                    next_s.fsm = PQCI_IDLE;
                end else if (MSIX_ACK) begin
                    // Every event sharing the sent vector is covered by this message
                    next_s.pend = s.pend & ~same_vec;
                    next_s.fsm  = PQCI_IDLE;
                end
            end
            default: begin
                next_s.fsm = PQCI_IDLE;
            end
        endcase

        // Unmapped events never become pending; new events win over the clear above
        for (int i = 0; i < NE; i++) begin
            if (!MSIX_EN || !mapped[i])
                next_s.pend[i] = 1'b0;
            else if (evt[i])
                next_s.pend[i] = 1'b1;
        end

        next_s.rdata = 32'h0000_0000;
        if (REG_RD) begin
            case (REG_ADDR)
                `PQCI_OFS_QSEL:  next_s.rdata = {16'h0000, s.qsel};
                `PQCI_OFS_QVEC:  next_s.rdata = {16'h0000, sel_vec};
                `PQCI_OFS_CVEC:  next_s.rdata = {16'h0000, map_vec[NQ]};
                `PQCI_OFS_CAUSE: next_s.rdata = {30'h0, s.cause};
                `PQCI_OFS_STAT:  next_s.rdata = {16'(s.pend), 13'h0, s.fsm == PQCI_SEND, MSIX_EN, s.intx};
                default:         next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            s.qsel  <= `PQCI_QSEL_RST;
            s.cause <= `PQCI_CAUSE_RST;
            s.intx  <= 1'b0;
            s.pend  <= '0;
            s.fsm   <= PQCI_IDLE;
            s.vec   <= `PQCI_NO_VECTOR;
            s.rdata <= 32'h0000_0000;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign REG_RDATA = s.rdata;
    assign MSIX_REQ  = s.fsm == PQCI_SEND && MSIX_EN;
    assign MSIX_VEC  = s.vec[10:0];
    assign INTX_N    = !s.intx;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_qcause_then_line;
        s.cause[`PQCI_CAUSE_QUEUE] ##1 (!INTX_N || !$past(CE));
    endsequence

    sequence s_ccause_then_line;
        s.cause[`PQCI_CAUSE_CFG] ##1 (!INTX_N || !$past(CE));
    endsequence

    property p_queue_legacy;
        CE && !MSIX_EN && (|QUEUE_EVT) |=> s_qcause_then_line;
    endproperty
    a_queue_legacy: assert property (p_queue_legacy) else $error("queue event missed cause bit 0 or line");

    property p_cfg_legacy;
        CE && !MSIX_EN && CFG_EVT |=> s_ccause_then_line;
    endproperty
    a_cfg_legacy: assert property (p_cfg_legacy) else $error("config event missed cause bit 1 or line");

    property p_queue_msix;
        CE && MSIX_EN && QUEUE_EVT[0] && map_vec[0] != `PQCI_NO_VECTOR |=> s.pend[0];
    endproperty
    a_queue_msix: assert property (p_queue_msix) else $error("mapped queue event not pending");

    property p_queue_nomap;
        $rose(s.pend[0]) |-> $past(map_vec[0]) != `PQCI_NO_VECTOR && $past(MSIX_EN);
    endproperty
    a_queue_nomap: assert property (p_queue_nomap) else $error("unmapped queue event became pending");

    property p_cfg_msix;
        CE && MSIX_EN && CFG_EVT && map_vec[NQ] != `PQCI_NO_VECTOR |=> s.pend[NQ];
    endproperty
    a_cfg_msix: assert property (p_cfg_msix) else $error("mapped config event not pending");

    property p_cfg_nomap;
        $rose(s.pend[NQ]) |-> $past(map_vec[NQ]) != `PQCI_NO_VECTOR;
    endproperty
    a_cfg_nomap: assert property (p_cfg_nomap) else $error("unmapped config event became pending");

    property p_msg_valid;
        MSIX_REQ |-> {5'h00, MSIX_VEC} <= TABLE_SIZE && s.vec <= `PQCI_VEC_MAX;
    endproperty
    a_msg_valid: assert property (p_msg_valid) else $error("message sent with invalid vector");

    property p_coalesce;
        CE && MSIX_REQ && MSIX_ACK && same_vec[0] && !QUEUE_EVT[0] |=> !s.pend[0];
    endproperty
    a_coalesce: assert property (p_coalesce) else $error("queue sharing sent vector still pending");

    property p_cause_read;
        CE && REG_RD && REG_ADDR == `PQCI_OFS_CAUSE && !(|QUEUE_EVT) && !CFG_EVT
            |=> s.cause == 2'h0 && REG_RDATA == {30'h0, $past(s.cause)};
    endproperty
    a_cause_read: assert property (p_cause_read) else $error("cause read did not return and clear");

    property p_cvec_read;
        CE && REG_RD && REG_ADDR == `PQCI_OFS_CVEC |=> REG_RDATA == {16'h0000, $past(map_vec[NQ])};
    endproperty
    a_cvec_read: assert property (p_cvec_read) else $error("config mapping read back wrong");

    property p_reset_unmap;
        @(posedge REF_CLK) disable iff (1'b0)
        !RST_N |=> map_vec[0] == `PQCI_NO_VECTOR && map_vec[NQ] == `PQCI_NO_VECTOR;
    endproperty
    a_reset_unmap: assert property (p_reset_unmap) else $error("mapping not cleared by reset");

    property p_bad_map;
        CE && REG_WR && REG_ADDR == `PQCI_OFS_CVEC && REG_WDATA[15:0] > TABLE_SIZE
            |=> map_vec[NQ] == `PQCI_NO_VECTOR;
    endproperty
    a_bad_map: assert property (p_bad_map) else $error("unhonourable mapping not reported");

    property p_line_drop;
        CE && s.cause == 2'h0 |=> INTX_N;
    endproperty
    a_line_drop: assert property (p_line_drop) else $error("legacy line held with empty cause");

endmodule

/* bench/pqci_host.sv */
// PCI core model: takes MSI-X messages after a chosen wait and logs them
module pqci_host (
    input  wire logic        clk,    // Block clock
    input  wire logic        rst_n,  // Synchronous reset, active low
    input  wire logic        req,    // Message request from the block
    input  wire logic [10:0] vec,    // Table entry of the message
    output logic             ack     // Message taken, one cycle
);
    timeunit 1ns;
    timeprecision 1ps;

    int          lat = 0;
    int          cnt;
    logic [10:0] sent[$];

    // Notification word the driver writes for a queue
    function automatic logic [31:0] notify_word(input logic tok_feat, input logic ext, input logic [15:0] idx,
                                                input logic [15:0] tok, input logic [15:0] nxt);
        logic [15:0] qn;
        qn = tok_feat ? tok : idx;
        return ext ? {nxt, qn} : {16'h0000, qn};
    endfunction

    // Request is held until the edge that sees ack high
    always @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
            cnt <= 0;
        end else if (ack || !req) begin
            ack <= 1'b0;
            cnt <= 0;
        end else if (cnt >= lat) begin
            ack <= 1'b1;
            sent.push_back(vec);
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* bench/tb_pci_queue_config_interrupts.sv */
// Self-checking bench for the queue/config interrupt block
`include "pqci_consts.svh"
module tb_pci_queue_config_interrupts import pqci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        we, re, ce, msix_en, cfg_evt, ack, req, intx_n;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  qevt;
    logic [10:0] vec;
    int          errors = 0;
    int          num_checks = 0;
    int          seed = 85;
    int          q;
    int          exp_q[$];

    always #25 clk = ~clk;

    pqci_top #(.NQ(4)) dut (
        .REF_CLK(clk), .RST_N(rst_n), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .MSIX_EN(msix_en), .QUEUE_EVT(qevt),
        .CFG_EVT(cfg_evt), .MSIX_ACK(ack), .MSIX_REQ(req), .MSIX_VEC(vec), .INTX_N(intx_n));

    pqci_host host (.clk(clk), .rst_n(rst_n), .req(req), .vec(vec), .ack(ack));

    // ****************************************************************
    // Bus and event tasks
    // ****************************************************************
    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        we <= 1'b1; addr <= a; wdata <= x;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge clk);
        re <= 1'b1; addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rdata, e, m);
    endtask

    task automatic ev(input logic [3:0] qs, input logic c);
        @(posedge clk);
        qevt <= qs; cfg_evt <= c;
        @(posedge clk);
        qevt <= 4'h0; cfg_evt <= 1'b0;
    endtask

    // Compares logged messages with the expected queue, then checks for silence
    task automatic drain;
        int n;
        while (exp_q.size() > 0) begin
            n = 0;
            while (host.sent.size() == 0 && n < 100) begin
                @(posedge clk);
                n++;
            end
            if (host.sent.size() == 0) begin
                errors++;
                $display("ERROR %0t message timeout", $time);
                results;
            end
            chk(32'(host.sent.pop_front()), 32'(exp_q.pop_front()), "message vector");
        end
        repeat (12) @(posedge clk);
        chk(32'(host.sent.size()), 32'h0, "unexpected message");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {we, re, msix_en, cfg_evt} = 4'h0;
        ce = 1'b1;
        addr = 8'h00; wdata = 32'h0; qevt = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`PQCI_OFS_CVEC, 32'h0000ffff, "cfg map reset");
        rdchk(`PQCI_OFS_QVEC, 32'h0000ffff, "queue map reset");
        chk(32'(intx_n), 32'h1, "legacy idle at reset");
        chk(host.notify_word(1'b1, 1'b0, 16'h0002, 16'h1234, 16'h0000), 32'h0000_1234, "notify token");
        chk(host.notify_word(1'b1, 1'b1, 16'h0002, 16'h1234, 16'h8001), 32'h8001_1234, "notify field");
        $display("test reset done");
        wr(`PQCI_OFS_CVEC, 32'h7ff);
        rdchk(`PQCI_OFS_CVEC, 32'h7ff, "cfg map top entry");
        wr(`PQCI_OFS_CVEC, 32'h800);
        rdchk(`PQCI_OFS_CVEC, 32'hffff, "cfg map refused");
        wr(`PQCI_OFS_QSEL, 32'h4);
        rdchk(`PQCI_OFS_QSEL, 32'h4, "queue select");
        wr(`PQCI_OFS_QVEC, 32'h3);
        rdchk(`PQCI_OFS_QVEC, 32'hffff, "absent queue map");
        $display("test mapping done");
        ev(4'h2, 1'b1);
        @(posedge clk);
        #1 chk(32'(intx_n), 32'h0, "legacy asserted");
        rdchk(`PQCI_OFS_STAT, 32'h1, "status legacy");
        rdchk(`PQCI_OFS_CAUSE, 32'h3, "cause both");
        @(posedge clk);
        #1 chk(32'(intx_n), 32'h1, "legacy released");
        rdchk(`PQCI_OFS_CAUSE, 32'h0, "cause cleared");
        ev(4'h8, 1'b0);
        rdchk(`PQCI_OFS_CAUSE, 32'h1, "cause queue");
        ev(4'h0, 1'b1);
        rdchk(`PQCI_OFS_CAUSE, 32'h2, "cause config");
        drain;
        $display("test legacy done");
        @(posedge clk);
        msix_en <= 1'b1;
        wr(`PQCI_OFS_QSEL, 32'h1);
        wr(`PQCI_OFS_QVEC, 32'h3);
        wr(`PQCI_OFS_CVEC, 32'h5);
        ev(4'h2, 1'b0);
        exp_q.push_back(3);
        drain;
        ev(4'h0, 1'b1);
        exp_q.push_back(5);
        drain;
        ev(4'h4, 1'b0);
        drain;
        wr(`PQCI_OFS_CVEC, 32'hffff);
        ev(4'h0, 1'b1);
        drain;
        host.lat = 2;
        wr(`PQCI_OFS_QSEL, 32'h0);
        wr(`PQCI_OFS_QVEC, 32'h7);
        wr(`PQCI_OFS_CVEC, 32'h7);
        ev(4'h3, 1'b1);
        exp_q.push_back(7);
        exp_q.push_back(3);
        drain;
        $display("test msix done");
        for (int i = 0; i < 8; i++) begin
            q = $unsigned($random(seed)) % 4;
            v = $random(seed) & 32'h7ff;
            host.lat = $unsigned($random(seed)) % 4;
            wr(`PQCI_OFS_QSEL, 32'(q));
            wr(`PQCI_OFS_QVEC, v);
            rdchk(`PQCI_OFS_QVEC, v, "random map");
            ev(4'(1 << q), 1'b0);
            exp_q.push_back(int'(v));
            drain;
        end
        $display("test random done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`PQCI_OFS_CVEC, 32'hffff, "cfg map after reset");
        $display("test second reset done");
        @(posedge clk);
        ce <= 1'b0;
        wr(`PQCI_OFS_CVEC, 32'h9);
        @(posedge clk);
        ce <= 1'b1;
        rdchk(`PQCI_OFS_CVEC, 32'hffff, "write frozen by enable");
        $display("test clock enable done");
        results;
    end
endmodule
